/* common/csd_pkg.sv */
/*
  csd_pkg: opcode fields, phase and state types for the compare-skip and
  decimal adjust execution block. Assumes a core with a four-phase
  instruction clock built from ref_clk.
*/
`default_nettype none
package csd_pkg;
  // opcode upper-byte patterns, access bit masked off (bits 15:9)
  localparam logic [6:0]  OPC_CMP_LESS    = 7'h30;
  localparam logic [6:0]  OPC_CMP_EQUAL   = 7'h31;
  localparam logic [6:0]  OPC_CMP_GREATER = 7'h32;
  localparam logic [15:0] OPC_DEC_ADJUST  = 16'h0007;
  localparam int          ACCESS_BIT_POS  = 8;
  localparam logic [7:0]  INDEXED_MAX     = 8'h5F;
  localparam logic [3:0]  BCD_LIMIT       = 4'h9;
  localparam logic [3:0]  BCD_FIX         = 4'h6;
  localparam logic [7:0]  ACC_RESET       = 8'h00;

  typedef enum logic [1:0] {CSD_Q1, CSD_Q2, CSD_Q3, CSD_Q4} csd_phase_e;
  typedef enum logic [1:0] {CSD_EXEC, CSD_SKIP1, CSD_SKIP2} csd_state_e;
  typedef enum logic [2:0] {
    CSD_OP_NONE, CSD_OP_LESS, CSD_OP_EQUAL, CSD_OP_GREATER, CSD_OP_ADJ
  } csd_op_e;

  // file operand request toward data memory
  typedef struct packed {
    logic       read;
    logic       access_bank;
    logic       indexed;
    logic [3:0] bank;
    logic [7:0] addr;
  } csd_file_req_s;

  // status flags touched here
  typedef struct packed {
    logic carry;
    logic half_carry;
  } csd_flags_s;
endpackage
`default_nettype wire

/* rtl/csd_exec.sv */
/*
  csd_exec: execution of three compare-and-skip instructions and decimal
  adjust of the accumulator. Assumes the instruction word and the
  next-word-is-two-word flag are stable from Q1 of each cycle, file data
  returns in Q2, and all inputs come from logic on ref_clk.
  The accumulator has no load path here: only reset and decimal adjust
  change it. Flags otherwise follow flags_in from the core.
*/
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - decode greater compare from 0110 010a
// - decode less compare from 0110 000a
// - greater skips when file exceeds accumulator
// - less skips when file below accumulator
// - equal skips next when file equals accumulator
// - unsigned subtract, operands and flags untouched
// - skip discards fetched word, runs nop
// - two-word skipped instruction adds second nop
// - one word; one cycle, two on skip, three on skip of a two-word instruction
// - compare phases decode/read/process/no write
// - access bit picks access bank or pointer
// - indexed literal offset when a=0, f<=95
// - decimal adjust word 0007, one cycle
// - low nibble add 6 if >9 or half carry
// - adjusted packed bcd written to accumulator
module csd_exec
  import csd_pkg::*;
(
  input  wire logic                   ref_clk,
  input  wire logic                   rstn,
  input  wire logic [15:0]            instr_word,
  input  wire logic                   next_is_two_word,
  input  wire logic                   ext_set_enable,
  input  wire logic [3:0]             bank_select_pointer,
  input  wire logic [7:0]             file_data,
  input  wire csd_pkg::csd_flags_s    flags_in,
  output csd_pkg::csd_file_req_s      file_req,
  output logic [7:0]                  accumulator,
  output csd_pkg::csd_flags_s         flags_out,
  output csd_pkg::csd_phase_e         phase,
  output logic                        cycle_end,
  output logic                        discard_fetch,
  output logic                        nop_cycle
);
  import csd_pkg::*;

  csd_phase_e   phase_r;
  csd_state_e   state_r;
  csd_op_e      op_r;
  logic [7:0]   operand_r;
  logic         skip_r;
  logic [7:0]   acc_r;
  logic [7:0]   adj_r;
  logic         adj_carry_r;
  csd_flags_s   flags_r;
  csd_op_e      op_dec;
  logic [8:0]   diff;
  logic [4:0]   low_sum;
  logic [4:0]   high_sum;
  logic         low_fix;
  logic         high_fix;

  function automatic csd_op_e decode_op(input logic [15:0] w);
    csd_op_e o;
    o = CSD_OP_NONE;
    if (w[15:9] == OPC_CMP_GREATER) o = CSD_OP_GREATER;
    if (w[15:9] == OPC_CMP_LESS) o = CSD_OP_LESS;
    // equal pattern sits between less and greater
    if (w[15:9] == OPC_CMP_EQUAL) o = CSD_OP_EQUAL;
    if (w == OPC_DEC_ADJUST) o = CSD_OP_ADJ;
    return o;
  endfunction

  // shared test for the three compare opcodes
  function automatic logic is_compare(input csd_op_e o);
    return (o == CSD_OP_LESS) || (o == CSD_OP_EQUAL)
           || (o == CSD_OP_GREATER);
  endfunction

  assign op_dec = decode_op(instr_word);

  // phase counter wraps from Q4 back to Q1 on its own
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      phase_r <= CSD_Q1;
    end else begin
      phase_r <= csd_phase_e'(phase_r + 2'h1);
    end
  end

  // a word fetched under a nop is dropped here, never decoded
  // decode in Q1, skip cycles latch nothing
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      op_r <= CSD_OP_NONE;
    end else if (phase_r == CSD_Q1) begin
      op_r <= (state_r == CSD_EXEC) ? op_dec : CSD_OP_NONE;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      operand_r <= 8'h00;
    end else if (phase_r == CSD_Q2) begin
      operand_r <= (op_r == CSD_OP_ADJ) ? acc_r : file_data;
    end
  end

  // nine bits so the borrow tells which operand is larger
  // unsigned file minus accumulator, nothing stored
  assign diff = {1'b0, operand_r} - {1'b0, acc_r};

  assign low_fix  = (operand_r[3:0] > BCD_LIMIT) || flags_r.half_carry;
  assign low_sum  = {1'b0, operand_r[3:0]}
                  + (low_fix ? {1'b0, BCD_FIX} : 5'h00);
  // high nibble correction with low carry
  assign high_fix = (operand_r[7:4] > BCD_LIMIT) || flags_r.carry;
  assign high_sum = {1'b0, operand_r[7:4]}
                  + (high_fix ? {1'b0, BCD_FIX} : 5'h00)
                  + {4'h0, low_sum[4]};

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      skip_r <= 1'b0;
    end else if (phase_r == CSD_Q3) begin
      unique case (op_r)
        // strictly greater, no borrow and nonzero
        CSD_OP_GREATER: skip_r <= !diff[8] && (diff[7:0] != 8'h00);
        CSD_OP_LESS:    skip_r <= diff[8];
        CSD_OP_EQUAL:   skip_r <= (diff == 9'h000);
        // any other op clears it, so no skip lingers
        default:        skip_r <= 1'b0;
      endcase
    end
  end

  // adjusted byte and carry, Q3
  // only an adjust loads these, which saves needless toggling
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      adj_r       <= 8'h00;
      adj_carry_r <= 1'b0;
    end else if (phase_r == CSD_Q3 && op_r == CSD_OP_ADJ) begin
      adj_r       <= {high_sum[3:0], low_sum[3:0]};
      adj_carry_r <= high_sum[4] || flags_r.carry;
    end
  end

  // write back in Q4, only adjust writes
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      acc_r <= ACC_RESET;
    end else if (phase_r == CSD_Q4 && op_r == CSD_OP_ADJ) begin
      acc_r <= adj_r;
    end
  end

  // flags follow the core; adjust alters carry alone
  // back-to-back adjusts chain on the carry held here
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      flags_r <= '0;
    end else if (phase_r == CSD_Q4 && op_r == CSD_OP_ADJ) begin
      flags_r.carry      <= adj_carry_r;
      flags_r.half_carry <= flags_in.half_carry;
    end else if (op_r != CSD_OP_ADJ) begin
      flags_r <= flags_in;
    end
  end

  // the two-word hint matters only at the end of the first nop
  // skip moves to nop cycles
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= CSD_EXEC;
    end else if (phase_r == CSD_Q4) begin
      unique case (state_r)
        CSD_EXEC:  state_r <= skip_r ? CSD_SKIP1 : CSD_EXEC;
        // second nop for a two-word victim
        CSD_SKIP1: state_r <= next_is_two_word ? CSD_SKIP2 : CSD_EXEC;
        CSD_SKIP2: state_r <= CSD_EXEC;
        default:   state_r <= CSD_EXEC;
      endcase
    end
  end

  // bank and address pass straight through; data memory picks the use
  // access bank or pointer selected bank
  always_comb begin
    // only a compare reads a file in Q2
    file_req.read        = (phase_r == CSD_Q2) && is_compare(op_r);
    file_req.access_bank = !instr_word[ACCESS_BIT_POS];
    file_req.bank        = bank_select_pointer;
    file_req.addr        = instr_word[7:0];
    file_req.indexed     = !instr_word[ACCESS_BIT_POS] && ext_set_enable
                           && (instr_word[7:0] <= INDEXED_MAX);
  end

  assign accumulator   = acc_r;
  assign flags_out     = flags_r;
  assign phase         = phase_r;
  assign cycle_end     = (phase_r == CSD_Q4);
  // discard_fetch pulses once; the fetch unit drops its word
  assign discard_fetch = (state_r == CSD_EXEC) && skip_r
                         && (phase_r == CSD_Q4);
  assign nop_cycle     = (state_r != CSD_EXEC);
endmodule // csd_exec
`default_nettype wire

/* verif/csd_exec_chk.sv */
/* csd_exec_chk: assertions on csd_exec ports.
   assumes one clock and an async active-low reset. */
`timescale 1ns/10ps
`default_nettype none
module csd_exec_chk
  import csd_pkg::*;
(
  input wire logic          ref_clk,
  input wire logic          rstn,
  input wire logic [15:0]   instr_word,
  input wire logic          next_is_two_word,
  input wire logic          ext_set_enable,
  input wire logic [3:0]    bank_select_pointer,
  input wire csd_file_req_s file_req,
  input wire logic [7:0]    accumulator,
  input wire csd_phase_e    phase,
  input wire logic          discard_fetch,
  input wire logic          nop_cycle
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  wire logic rd = file_req.read;
  wire logic a0 = !instr_word[8];
  sequence nops_s; nop_cycle [*4]; endsequence
  a_read_decode:
    assert property (phase == CSD_Q2 && !nop_cycle && instr_word[15:11]
      == 5'h0C && instr_word[10:9] != 2'h3 |-> rd) else $error("no read");
  a_bank_pick:
    assert property (rd |-> file_req.access_bank == a0 && (a0 ||
      file_req.bank == bank_select_pointer)) else $error("bad bank");
  a_indexed_mode:
    assert property (rd |-> file_req.indexed == (a0 && ext_set_enable &&
      instr_word[7:0] <= INDEXED_MAX)) else $error("bad indexed");
  a_skip_nop:
    assert property (discard_fetch |-> phase == CSD_Q4 ##1 nops_s)
      else $error("no nop");
  a_two_word:
    assert property (discard_fetch ##4 next_is_two_word |=> nops_s)
      else $error("no second nop");
  a_one_word:
    assert property (discard_fetch ##4 !next_is_two_word |=> !nop_cycle)
      else $error("extra nop");
  a_acc_hold:
    assert property (phase == CSD_Q1 && instr_word != OPC_DEC_ADJUST
      |=> $stable(accumulator) [*4]) else $error("acc changed");
  a_acc_q4:
    assert property ($changed(accumulator) |-> $past(phase) == CSD_Q4)
      else $error("acc write off q4");
endmodule // csd_exec_chk
bind csd_exec csd_exec_chk u_chk (.*);
`default_nettype wire

/* verif/tb.sv */
/* tb: random instruction stream into csd_exec, scoreboarded.
   assumes the checker binds itself. */
`timescale 1ns/10ps
`default_nettype none
module tb;
  import csd_pkg::*;
  logic          ref_clk, rstn, next_is_two_word, ext_set_enable;
  logic          cycle_end, discard_fetch, nop_cycle, sk;
  logic          fc, fh, pc, ph, pa, padj;
  logic [15:0]   instr_word;
  logic [3:0]    bank_select_pointer;
  logic [4:0]    lo, hi;
  logic [7:0]    file_data, accumulator, ad, macc;
  logic [31:0]   r;
  logic [11:0]   n, notes[$];
  logic [6:0]    opc[3] = '{OPC_CMP_LESS, OPC_CMP_EQUAL, OPC_CMP_GREATER};
  csd_flags_s    flags_in, flags_out;
  csd_file_req_s file_req;
  csd_phase_e    phase;
  int            failures, checks_done, pend, k;
  csd_exec dut_u (
    .ref_clk             (ref_clk),
    .rstn                (rstn),
    .instr_word          (instr_word),
    .next_is_two_word    (next_is_two_word),
    .ext_set_enable      (ext_set_enable),
    .bank_select_pointer (bank_select_pointer),
    .file_data           (file_data),
    .flags_in            (flags_in),
    .file_req            (file_req),
    .accumulator         (accumulator),
    .flags_out           (flags_out),
    .phase               (phase),
    .cycle_end           (cycle_end),
    .discard_fetch       (discard_fetch),
    .nop_cycle           (nop_cycle)
  );
  initial begin
    ref_clk = 0;
    forever #25 ref_clk = ~ref_clk;
  end
  task automatic check(string what, logic [11:0] seen, want);
    checks_done++;
    if (seen !== want) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // acc read one phase after q4, once the write has landed
  initial forever begin
    @(negedge ref_clk);
    if (rstn && phase == CSD_Q4 && notes.size() > 0) begin
      n = notes.pop_front();
      check("end", cycle_end, 1'b1);
      check("skip", {discard_fetch, nop_cycle}, n[11:10]);
      @(negedge ref_clk);
      check("flags", flags_out, n[9:8]);
      check("acc", accumulator, n[7:0]);
    end
  end
  initial begin
    {rstn, next_is_two_word, ext_set_enable, bank_select_pointer} = '0;
    {file_data, flags_in, instr_word} = '0;
    failures = 0;
    checks_done = 0;
    r = $urandom(32'hd012);
    for (int t = 0; t < 2; t++) begin
      rstn = 0;
      notes.delete();
      macc = ACC_RESET;
      pend = 0;
      padj = 1'b0;
      repeat (6) @(negedge ref_clk);
      rstn = 1;
      for (int c = 0; c < 300; c++) begin
        r = $urandom;
        k = $urandom_range(4);
        ad = r[8] ? 8'h5E + 8'(r[10:9]) : r[7:0];
        file_data = (r[11] && k == 1) ? macc : r[19:12];
        {ext_set_enable, bank_select_pointer, flags_in} = r[26:20];
        instr_word = k > 3 ? 16'hFFFF : k > 2 ? OPC_DEC_ADJUST :
          {opc[k], r[27], ad};
        check("phase", phase, CSD_Q1);
        pa = padj;
        padj = 1'b0;
        if (pend > 0) begin
          notes.push_back({2'b01, flags_in, macc});
          pend--;
        end else if (k < 3) begin
          sk = k == 0 ? file_data < macc : (k == 1 ? file_data == macc :
            file_data > macc);
          next_is_two_word = r[28];
          pend = sk ? 1 + next_is_two_word : 0;
          notes.push_back({sk, 1'b0, flags_in, macc});
        end else if (k == 3) begin
          // back-to-back adjusts chain on the carry just produced
          {fc, fh} = pa ? {pc, ph} : flags_in;
          lo = macc[3:0] + ((macc[3:0] > BCD_LIMIT || fh) ? BCD_FIX : 4'h0);
          // high nibble, carry kept if set
          hi = macc[7:4] + lo[4] + ((macc[7:4] > BCD_LIMIT || fc) ? BCD_FIX :
            4'h0);
          macc = {hi[3:0], lo[3:0]};
          {pc, ph} = {hi[4] | fc, flags_in.half_carry};
          padj = 1'b1;
          notes.push_back({2'b00, pc, ph, macc});
        end else begin
          notes.push_back({2'b00, flags_in, macc});
        end
        repeat (4) @(negedge ref_clk);
      end
      @(negedge ref_clk);
      $display("stream %0d ended, checks %0d", t, checks_done);
    end
    check("queue", notes.size(), 0);
    complete_run();
  end
endmodule // tb
`default_nettype wire
